// ===== logic/dsci_top.sv
// Overview of operation
// - frequency source picks speed reference origin
// - run source picks run/stop command origin
// - link speed used only when source is comm
// - speed word is 0.01 Hz, max 400 Hz
// - command bit0 runs forward, bit1 reverse
// - command word zero stops via stop method
// - two-byte CRC16 checked before acting
// - reset link: node 1, 9600, 8N1
// - link sets speed, commands, writes parameters
// - display codes 0 Hz, 1 %, 2-38 rpm
// - codes 40-39999 user scale, 0-3 decimals
// - run and direction points writable, relays read-only
// - fieldbus error codes 01,02,03,05,10
// - error 00 until identify after power-up
// - keypad run starts forward, direction key toggles
// - stop key stops per stop method
// - reverse lock 1 blocks reverse commands
// - frequency source resets to keypad
`timescale 1ns/1ps
`default_nettype none
module dsci_top #(
   parameter int unsigned BIT_CYCLES = dsci_pkg::BIT_CYCLES_DEFAULT,
   parameter int unsigned GAP_CYCLES = dsci_pkg::GAP_CYCLES_DEFAULT,
   parameter logic [7:0] NODE_ADDR = dsci_pkg::NODE_ADDR_DEFAULT
) (
   input wire logic SYS_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic SERIAL_RX_IN,
   input wire logic KEY_RUN_IN,
   input wire logic KEY_STOP_IN,
   input wire logic DIRECTION_KEY_IN,
   input wire dsci_pkg::dsci_run_req_s TERM_REQ_IN,
   input wire dsci_pkg::dsci_run_req_s SEQ_REQ_IN,
   input wire dsci_pkg::dsci_freq_in_s FREQ_IN,
   input wire logic [2:0] RELAY_STATE_IN,
   input wire logic FB_IDENTIFY_IN,
   input wire logic FB_RUN_WR_IN,
   input wire logic FB_DIR_WR_IN,
   input wire logic FB_WR_VALUE_IN,
   output logic RUN_OUT,
   output logic REVERSE_OUT,
   output logic STOP_COAST_OUT,
   output logic [15:0] SPEED_REF_OUT,
   output logic [15:0] RUN_CMD_WORD_OUT,
   output logic [15:0] SPEED_REF_WORD_OUT,
   output logic [2:0] FREQ_SRC_OUT,
   output logic [1:0] RUN_SRC_OUT,
   output var dsci_pkg::dsci_disp_s DISPLAY_OUT,
   output var dsci_pkg::dsci_fb_status_s FB_STATUS_OUT,
   output logic FRAME_DONE_OUT
);
   localparam int unsigned GW = $clog2(GAP_CYCLES + 1);
   localparam logic [GW-1:0] GAP_LAST = GW'(GAP_CYCLES - 1);

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ dsci_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

   function automatic logic disp_ok(input logic [15:0] v);
      return v <= dsci_pkg::DISP_RPM_MAX ||
         (v >= dsci_pkg::DISP_USER0_MIN && v <= dsci_pkg::DISP_USER0_MAX) ||
         (v >= dsci_pkg::DISP_USER1_MIN && v <= dsci_pkg::DISP_USER1_MAX) ||
         (v >= dsci_pkg::DISP_USER2_MIN && v <= dsci_pkg::DISP_USER2_MAX) ||
         (v >= dsci_pkg::DISP_USER3_MIN && v <= dsci_pkg::DISP_USER3_MAX);
   endfunction

   function automatic dsci_pkg::dsci_disp_s disp_decode(input logic [15:0] v);
      dsci_pkg::dsci_disp_s d;
      d.decimals = 2'h2;
      if (v == dsci_pkg::DISP_HZ_CODE) d.kind = dsci_pkg::DISP_HZ;
      else if (v == dsci_pkg::DISP_PCT_CODE) d.kind = dsci_pkg::DISP_PCT;
      else if (v <= dsci_pkg::DISP_RPM_MAX) begin
         d.kind = dsci_pkg::DISP_RPM;
         d.decimals = 2'h0;
      end else begin
         d.kind = dsci_pkg::DISP_USER;
         if (v <= dsci_pkg::DISP_USER0_MAX) d.decimals = 2'h0;
         else if (v <= dsci_pkg::DISP_USER1_MAX) d.decimals = 2'h1;
         else if (v <= dsci_pkg::DISP_USER2_MAX) d.decimals = 2'h2;
         else d.decimals = 2'h3;
      end
      return d;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [7:0] rx_byte;
   logic rx_valid, rx_ferr;

   dsci_uart_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
      .clk_in(SYS_CLK_IN),
      .rst_in(SYS_RST_IN),
      .rxd_in(SERIAL_RX_IN),
      .data_out(rx_byte),
      .valid_out(rx_valid),
      .frame_err_out(rx_ferr)
   );

   logic [7:0] frame_q [8];
   logic [5:0] cnt_q;
   logic [15:0] crc_q;
   logic ferr_q;
   logic [GW-1:0] gap_q;
   logic frame_end;

   // frame closes after a silence of three and a half characters
   assign frame_end = cnt_q != '0 && gap_q == GAP_LAST && !rx_valid;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         cnt_q <= '0;
         crc_q <= dsci_pkg::CRC_INIT;
         ferr_q <= 1'b0;
         gap_q <= '0;
      end else if (rx_valid) begin
         gap_q <= '0;
         if (cnt_q != dsci_pkg::CNT_SAT) cnt_q <= cnt_q + 1'b1;
         crc_q <= crc_step(crc_q, rx_byte);
         ferr_q <= ferr_q | rx_ferr;
      end else if (frame_end) begin
         cnt_q <= '0;
         crc_q <= dsci_pkg::CRC_INIT;
         ferr_q <= 1'b0;
         gap_q <= '0;
      end else if (cnt_q != '0) begin
         gap_q <= gap_q + 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (rx_valid && cnt_q < dsci_pkg::FRAME_BYTES) begin
         frame_q[cnt_q[2:0]] <= rx_byte;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] reg_addr, reg_val;
   logic [7:0] err_d;
   logic for_us, range_ok;

   // address and value arrive high byte first
   assign reg_addr = {frame_q[2], frame_q[3]};
   assign reg_val = {frame_q[4], frame_q[5]};
   assign for_us = frame_end && frame_q[0] == NODE_ADDR;

   always_comb begin
      unique case (reg_addr)
         dsci_pkg::REG_RUN_CMD: range_ok = 1'b1;
         dsci_pkg::REG_SPEED_REF:
            range_ok = reg_val <= dsci_pkg::SPEED_REF_MAX;
         dsci_pkg::PAR_RUN_SRC: range_ok = reg_val <= dsci_pkg::RUN_SRC_MAX;
         dsci_pkg::PAR_FREQ_SRC: range_ok = reg_val <= dsci_pkg::FREQ_SRC_MAX;
         dsci_pkg::PAR_STOP_METHOD:
            range_ok = reg_val <= dsci_pkg::STOP_METHOD_MAX;
         dsci_pkg::PAR_REV_LOCK: range_ok = reg_val <= dsci_pkg::REV_LOCK_MAX;
         dsci_pkg::PAR_DISPLAY_UNIT: range_ok = disp_ok(reg_val);
         default: range_ok = 1'b0;
      endcase
   end

   always_comb begin
      if (cnt_q > dsci_pkg::MAX_FRAME_BYTES) err_d = dsci_pkg::ERR_TOO_LONG;
      else if (cnt_q != dsci_pkg::FRAME_BYTES) err_d = dsci_pkg::ERR_LENGTH;
      else if (crc_q != dsci_pkg::CRC_RESIDUE || ferr_q)
         err_d = dsci_pkg::ERR_CHECK;
      else if (frame_q[1] != dsci_pkg::FUNC_WRITE_SINGLE)
         err_d = dsci_pkg::ERR_UNSUPPORTED;
      else if (!range_ok) err_d = dsci_pkg::ERR_RANGE;
      else err_d = dsci_pkg::ERR_NONE;
   end

   logic wr;
   assign wr = for_us && err_d == dsci_pkg::ERR_NONE;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] cmd_q, spd_q, disp_code_q;
   logic [2:0] freq_src_q;
   logic [1:0] run_src_q, rev_lock_q;
   logic stop_method_q;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         spd_q <= '0;
         freq_src_q <= dsci_pkg::FSRC_KEYPAD;
         run_src_q <= dsci_pkg::RSRC_KEYPAD;
         stop_method_q <= dsci_pkg::STOP_DECEL;
         rev_lock_q <= '0;
         disp_code_q <= dsci_pkg::DISP_HZ_CODE;
      end else if (wr) begin
         unique case (reg_addr)
            dsci_pkg::REG_SPEED_REF: spd_q <= reg_val;
            dsci_pkg::PAR_RUN_SRC: run_src_q <= reg_val[1:0];
            dsci_pkg::PAR_FREQ_SRC: freq_src_q <= reg_val[2:0];
            dsci_pkg::PAR_STOP_METHOD: stop_method_q <= reg_val[0];
            dsci_pkg::PAR_REV_LOCK: rev_lock_q <= reg_val[1:0];
            dsci_pkg::PAR_DISPLAY_UNIT: disp_code_q <= reg_val;
            default: ;
         endcase
      end
   end

   localparam int unsigned CMD_FWD_IDX = dsci_pkg::CMD_FWD_BIT;
   localparam int unsigned CMD_REV_IDX = dsci_pkg::CMD_REV_BIT;

   // link writes win over fieldbus point writes in the same cycle
   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         cmd_q <= '0;
      end else if (wr && reg_addr == dsci_pkg::REG_RUN_CMD) begin
         cmd_q <= reg_val;
      end else if (FB_RUN_WR_IN) begin
         cmd_q[CMD_FWD_IDX] <= FB_WR_VALUE_IN && !REVERSE_OUT;
         cmd_q[CMD_REV_IDX] <= FB_WR_VALUE_IN && REVERSE_OUT;
      end else if (FB_DIR_WR_IN && (cmd_q[CMD_FWD_IDX] || cmd_q[CMD_REV_IDX]))
      begin
         cmd_q[CMD_FWD_IDX] <= !FB_WR_VALUE_IN;
         cmd_q[CMD_REV_IDX] <= FB_WR_VALUE_IN;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   logic kp_run_q, kp_rev_q, kp_sel;
   assign kp_sel = run_src_q == dsci_pkg::RSRC_KEYPAD;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         kp_run_q <= 1'b0;
         kp_rev_q <= 1'b0;
      end else if (kp_sel) begin
         if (KEY_STOP_IN) begin
            kp_run_q <= 1'b0;
         end else if (KEY_RUN_IN && !kp_run_q) begin
            kp_run_q <= 1'b1;
            kp_rev_q <= 1'b0;
         end else if (DIRECTION_KEY_IN &&
                      (kp_rev_q || rev_lock_q != dsci_pkg::REV_LOCK_ON)) begin
            kp_rev_q <= !kp_rev_q;
         end
      end
   end

   dsci_pkg::dsci_run_req_s req;
   logic blocked;
   always_comb begin
      unique case (run_src_q)
         dsci_pkg::RSRC_KEYPAD: req = '{run: kp_run_q, rev: kp_rev_q};
         dsci_pkg::RSRC_TERMINAL: req = TERM_REQ_IN;
         // either bit runs; reverse takes precedence when both set
         dsci_pkg::RSRC_COMM: req = '{run: cmd_q[CMD_FWD_IDX] ||
            cmd_q[CMD_REV_IDX], rev: cmd_q[CMD_REV_IDX]};
         dsci_pkg::RSRC_SEQ: req = SEQ_REQ_IN;
      endcase
   end
   assign blocked = req.rev && rev_lock_q == dsci_pkg::REV_LOCK_ON;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         RUN_OUT <= 1'b0;
         REVERSE_OUT <= 1'b0;
         STOP_COAST_OUT <= dsci_pkg::STOP_DECEL;
      end else begin
         RUN_OUT <= req.run && !blocked;
         REVERSE_OUT <= req.rev && !blocked;
         STOP_COAST_OUT <= stop_method_q;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         SPEED_REF_OUT <= '0;
      end else begin
         unique case (freq_src_q)
            dsci_pkg::FSRC_ANALOG: SPEED_REF_OUT <= FREQ_IN.analog;
            dsci_pkg::FSRC_UPDOWN: SPEED_REF_OUT <= FREQ_IN.updown;
            dsci_pkg::FSRC_COMM: SPEED_REF_OUT <= spd_q;
            dsci_pkg::FSRC_PULSE: SPEED_REF_OUT <= FREQ_IN.pulse;
            dsci_pkg::FSRC_PID: SPEED_REF_OUT <= FREQ_IN.pid;
            default: SPEED_REF_OUT <= FREQ_IN.keypad;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic identified_q;
   logic [7:0] err_q;

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         identified_q <= 1'b0;
         err_q <= dsci_pkg::ERR_NONE;
      end else begin
         if (FB_IDENTIFY_IN) identified_q <= 1'b1;
         if (for_us) err_q <= err_d;
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
         FB_STATUS_OUT <= '0;
         RUN_CMD_WORD_OUT <= '0;
         SPEED_REF_WORD_OUT <= '0;
         FREQ_SRC_OUT <= dsci_pkg::FSRC_KEYPAD;
         RUN_SRC_OUT <= dsci_pkg::RSRC_KEYPAD;
         DISPLAY_OUT <= '{kind: dsci_pkg::DISP_HZ, decimals: 2'h2};
         FRAME_DONE_OUT <= 1'b0;
      end else begin
         FB_STATUS_OUT.run_stop_point <= RUN_OUT;
         FB_STATUS_OUT.direction_point <= REVERSE_OUT;
         FB_STATUS_OUT.relay_output_one <= RELAY_STATE_IN[0];
         FB_STATUS_OUT.relay_output_two <= RELAY_STATE_IN[1];
         FB_STATUS_OUT.relay_output_three <= RELAY_STATE_IN[2];
         FB_STATUS_OUT.error_code <=
            identified_q ? err_q : dsci_pkg::ERR_NONE;
         RUN_CMD_WORD_OUT <= cmd_q;
         SPEED_REF_WORD_OUT <= spd_q;
         FREQ_SRC_OUT <= freq_src_q;
         RUN_SRC_OUT <= run_src_q;
         DISPLAY_OUT <= disp_decode(disp_code_q);
         FRAME_DONE_OUT <= wr;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic comm_run;
   assign comm_run = run_src_q == dsci_pkg::RSRC_COMM &&
      rev_lock_q != dsci_pkg::REV_LOCK_ON;

   sequence s_key_start;
      kp_sel && KEY_RUN_IN && !KEY_STOP_IN && !kp_run_q ##1
      kp_sel && rev_lock_q != dsci_pkg::REV_LOCK_ON;
   endsequence

   AST_RESET_KEYPAD: assert property (@(posedge SYS_CLK_IN)
      $fell(SYS_RST_IN) |-> freq_src_q == dsci_pkg::FSRC_KEYPAD)
      else $error("frequency source not keypad after reset");
   AST_KEYPAD_SPEED: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) freq_src_q == dsci_pkg::FSRC_KEYPAD |=>
      SPEED_REF_OUT == $past(FREQ_IN.keypad))
      else $error("keypad speed not followed");
   AST_COMM_SPEED: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) freq_src_q == dsci_pkg::FSRC_COMM |=>
      SPEED_REF_OUT == $past(spd_q))
      else $error("link speed not followed");
   AST_SPEED_MAX: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) spd_q <= dsci_pkg::SPEED_REF_MAX)
      else $error("speed word above 400 Hz");
   AST_CMD_FWD: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) comm_run && cmd_q[1:0] == 2'h1 |=>
      RUN_OUT && !REVERSE_OUT)
      else $error("forward command not run forward");
   AST_CMD_BOTH: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) comm_run && cmd_q[1:0] == 2'h3 |=>
      RUN_OUT && REVERSE_OUT)
      else $error("both bits did not run reverse");
   AST_CMD_STOP: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) run_src_q == dsci_pkg::RSRC_COMM &&
      cmd_q[1:0] == 2'h0 |=> !RUN_OUT)
      else $error("zero command did not stop");
   AST_REV_LOCK: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) rev_lock_q == dsci_pkg::REV_LOCK_ON |=>
      !REVERSE_OUT)
      else $error("reverse while locked");
   AST_KEY_FWD: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) s_key_start |=> RUN_OUT && !REVERSE_OUT)
      else $error("run key did not start forward");
   AST_BAD_CHECK: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) frame_end && err_d == dsci_pkg::ERR_CHECK
      |=> $stable(spd_q) ##1 !FRAME_DONE_OUT)
      else $error("frame acted on despite check failure");
   AST_NO_IDENT: assert property (@(posedge SYS_CLK_IN)
      disable iff (SYS_RST_IN) !identified_q |=>
      FB_STATUS_OUT.error_code == dsci_pkg::ERR_NONE)
      else $error("error code shown before identify");
endmodule
`default_nettype wire

// ===== logic/dsci_pkg.sv
package dsci_pkg;
   localparam int unsigned CLK_FREQ_HZ = 200_000_000;
   localparam int unsigned BAUD_DEFAULT = 9600;
   localparam int unsigned BIT_CYCLES_DEFAULT = CLK_FREQ_HZ / BAUD_DEFAULT;
   localparam int unsigned CHAR_BITS = 10;
   localparam int unsigned GAP_CHARS_X10 = 35;
   localparam int unsigned GAP_CYCLES_DEFAULT =
      BIT_CYCLES_DEFAULT * CHAR_BITS * GAP_CHARS_X10 / 10;
   localparam logic [2:0] RX_LAST_BIT = 3'h7;

   localparam logic [7:0] NODE_ADDR_DEFAULT = 8'h01;
   localparam logic [7:0] FUNC_WRITE_SINGLE = 8'h06;
   localparam logic [5:0] FRAME_BYTES = 6'h08;
   localparam logic [5:0] MAX_FRAME_BYTES = 6'h20;
   localparam logic [5:0] CNT_SAT = 6'h21;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;
   localparam logic [15:0] CRC_RESIDUE = 16'h0000;

   localparam logic [15:0] REG_RUN_CMD = 16'h2501;
   localparam logic [15:0] REG_SPEED_REF = 16'h2502;
   localparam logic [15:0] PAR_RUN_SRC = 16'h0002;
   localparam logic [15:0] PAR_FREQ_SRC = 16'h0005;
   localparam logic [15:0] PAR_STOP_METHOD = 16'h0709;
   localparam logic [15:0] PAR_REV_LOCK = 16'h1101;
   localparam logic [15:0] PAR_DISPLAY_UNIT = 16'h1603;

   localparam int unsigned CMD_FWD_BIT = 0;
   localparam int unsigned CMD_REV_BIT = 1;
   localparam logic [15:0] SPEED_REF_MAX = 16'h9C40;
   localparam logic [15:0] RUN_SRC_MAX = 16'h0003;
   localparam logic [15:0] FREQ_SRC_MAX = 16'h0005;
   localparam logic [15:0] STOP_METHOD_MAX = 16'h0001;
   localparam logic [15:0] REV_LOCK_MAX = 16'h0002;

   localparam logic [2:0] FSRC_KEYPAD = 3'h0;
   localparam logic [2:0] FSRC_ANALOG = 3'h1;
   localparam logic [2:0] FSRC_UPDOWN = 3'h2;
   localparam logic [2:0] FSRC_COMM = 3'h3;
   localparam logic [2:0] FSRC_PULSE = 3'h4;
   localparam logic [2:0] FSRC_PID = 3'h5;
   localparam logic [1:0] RSRC_KEYPAD = 2'h0;
   localparam logic [1:0] RSRC_TERMINAL = 2'h1;
   localparam logic [1:0] RSRC_COMM = 2'h2;
   localparam logic [1:0] RSRC_SEQ = 2'h3;
   localparam logic STOP_DECEL = 1'b0;
   localparam logic [1:0] REV_LOCK_ON = 2'h1;

   localparam logic [15:0] DISP_HZ_CODE = 16'h0000;
   localparam logic [15:0] DISP_PCT_CODE = 16'h0001;
   localparam logic [15:0] DISP_RPM_MAX = 16'h0026;
   localparam logic [15:0] DISP_USER0_MIN = 16'h0028;
   localparam logic [15:0] DISP_USER0_MAX = 16'h270F;
   localparam logic [15:0] DISP_USER1_MIN = 16'h2711;
   localparam logic [15:0] DISP_USER1_MAX = 16'h4E1F;
   localparam logic [15:0] DISP_USER2_MIN = 16'h4E21;
   localparam logic [15:0] DISP_USER2_MAX = 16'h752F;
   localparam logic [15:0] DISP_USER3_MIN = 16'h7531;
   localparam logic [15:0] DISP_USER3_MAX = 16'h9C3F;

   localparam logic [7:0] ERR_NONE = 8'h00;
   localparam logic [7:0] ERR_UNSUPPORTED = 8'h01;
   localparam logic [7:0] ERR_CHECK = 8'h02;
   localparam logic [7:0] ERR_TOO_LONG = 8'h03;
   localparam logic [7:0] ERR_LENGTH = 8'h05;
   localparam logic [7:0] ERR_RANGE = 8'h0A;

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
      dsci_rx_state_e;
   typedef enum logic [1:0] {DISP_HZ, DISP_PCT, DISP_RPM, DISP_USER}
      dsci_disp_kind_e;

   typedef struct packed {
      logic run;
      logic rev;
   } dsci_run_req_s;

   typedef struct packed {
      logic [15:0] keypad;
      logic [15:0] analog;
      logic [15:0] updown;
      logic [15:0] pulse;
      logic [15:0] pid;
   } dsci_freq_in_s;

   typedef struct packed {
      dsci_disp_kind_e kind;
      logic [1:0] decimals;
   } dsci_disp_s;

   typedef struct packed {
      logic run_stop_point;
      logic direction_point;
      logic relay_output_one;
      logic relay_output_two;
      logic relay_output_three;
      logic [7:0] error_code;
   } dsci_fb_status_s;
endpackage

// ===== logic/dsci_uart_rx.sv
`timescale 1ns/1ps
`default_nettype none
module dsci_uart_rx #(
   parameter int unsigned BIT_CYCLES = dsci_pkg::BIT_CYCLES_DEFAULT
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic rxd_in,
   output logic [7:0] data_out,
   output logic valid_out,
   output logic frame_err_out
);
   localparam int unsigned CW = $clog2(BIT_CYCLES + 1);
   localparam logic [CW-1:0] FULL = CW'(BIT_CYCLES - 1);
   localparam logic [CW-1:0] HALF = CW'(BIT_CYCLES / 2 - 1);

   dsci_pkg::dsci_rx_state_e state_q;
   logic [CW-1:0] cnt_q;
   logic [2:0] bit_q;

   // 8N1, lsb first, each bit sampled at its centre
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state_q <= dsci_pkg::RX_IDLE;
         cnt_q <= '0;
         bit_q <= '0;
         data_out <= '0;
         valid_out <= 1'b0;
         frame_err_out <= 1'b0;
      end else begin
         valid_out <= 1'b0;
         frame_err_out <= 1'b0;
         unique case (state_q)
            dsci_pkg::RX_IDLE: begin
               cnt_q <= '0;
               if (!rxd_in) state_q <= dsci_pkg::RX_START;
            end
            dsci_pkg::RX_START: begin
               if (cnt_q == HALF) begin
                  cnt_q <= '0;
                  bit_q <= '0;
                  // a short low glitch is not a start bit
                  state_q <= rxd_in ? dsci_pkg::RX_IDLE : dsci_pkg::RX_DATA;
               end else cnt_q <= cnt_q + 1'b1;
            end
            dsci_pkg::RX_DATA: begin
               if (cnt_q == FULL) begin
                  cnt_q <= '0;
                  data_out <= {rxd_in, data_out[7:1]};
                  if (bit_q == dsci_pkg::RX_LAST_BIT) begin
                     state_q <= dsci_pkg::RX_STOP;
                  end else bit_q <= bit_q + 1'b1;
               end else cnt_q <= cnt_q + 1'b1;
            end
            dsci_pkg::RX_STOP: begin
               if (cnt_q == FULL) begin
                  state_q <= dsci_pkg::RX_IDLE;
                  valid_out <= 1'b1;
                  frame_err_out <= !rxd_in;
               end else cnt_q <= cnt_q + 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== testbench/dsci_mb_master.sv
`timescale 1ns/1ps
`default_nettype none
module dsci_mb_master #(
   parameter int unsigned BIT_CYCLES = 16
) (
   input wire logic clk_in,
   output logic txd_out
);
   initial txd_out = 1'b1;
   // one character: start, 8 data lsb first, stop
   task automatic send_byte(input logic [7:0] b);
      logic [9:0] sh;
      sh = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         txd_out = sh[i];
         repeat (BIT_CYCLES) @(negedge clk_in);
      end
   endtask
   // addr, write code, reg hi/lo, value hi/lo, check lo/hi
   task automatic send_frame(input logic [15:0] rg, input logic [15:0] val,
                             input logic bad);
      logic [47:0] m;
      logic [15:0] crc;
      m = {dsci_pkg::NODE_ADDR_DEFAULT, dsci_pkg::FUNC_WRITE_SINGLE, rg, val};
      crc = 16'hFFFF;
      for (int i = 0; i < 6; i++) begin
         crc = crc ^ {8'h00, m[47-8*i -: 8]};
         for (int j = 0; j < 8; j++) begin
            crc = crc[0] ? ((crc >> 1) ^ 16'hA001) : (crc >> 1);
         end
         send_byte(m[47-8*i -: 8]);
      end
      crc[0] = crc[0] ^ bad;
      send_byte(crc[7:0]);
      send_byte(crc[15:8]);
   endtask
endmodule
`default_nettype wire

// ===== testbench/test_drive_serial_command_interface.sv
`timescale 1ns/1ps
`default_nettype none
module test_drive_serial_command_interface;
   logic sys_clk, sys_rst, rxd, k_run, k_stop, k_dir, ident;
   logic run, rev, coast, done;
   logic [15:0] spd;
   logic [2:0] fsrc, relay;
   logic [1:0] rsrc;
   logic fb_run_wr, fb_dir_wr, fb_val;
   logic [15:0] cmdw, spdw;
   dsci_pkg::dsci_run_req_s req;
   dsci_pkg::dsci_freq_in_s freq;
   dsci_pkg::dsci_disp_s disp;
   dsci_pkg::dsci_fb_status_s fbs;
   int num_errors = 0;
   int num_checks = 0;
   dsci_mb_master #(.BIT_CYCLES(16)) master (.clk_in(sys_clk), .txd_out(rxd));
   // gap of 3.5 characters; must exceed one character time
   dsci_top #(.BIT_CYCLES(16), .GAP_CYCLES(560)) dut (
      .SYS_CLK_IN(sys_clk), .SYS_RST_IN(sys_rst), .SERIAL_RX_IN(rxd),
      .KEY_RUN_IN(k_run), .KEY_STOP_IN(k_stop), .DIRECTION_KEY_IN(k_dir),
      .TERM_REQ_IN(req), .SEQ_REQ_IN(req), .FREQ_IN(freq),
      .RELAY_STATE_IN(relay), .FB_IDENTIFY_IN(ident),
      .FB_RUN_WR_IN(fb_run_wr), .FB_DIR_WR_IN(fb_dir_wr),
      .FB_WR_VALUE_IN(fb_val), .RUN_OUT(run),
      .REVERSE_OUT(rev), .STOP_COAST_OUT(coast), .SPEED_REF_OUT(spd),
      .RUN_CMD_WORD_OUT(cmdw), .SPEED_REF_WORD_OUT(spdw), .FREQ_SRC_OUT(fsrc),
      .RUN_SRC_OUT(rsrc), .DISPLAY_OUT(disp), .FB_STATUS_OUT(fbs),
      .FRAME_DONE_OUT(done));
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      if (num_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask
   // key bits: run, stop, direction
   task automatic key(input logic [2:0] k);
      {k_run, k_stop, k_dir} = k;
      @(negedge sys_clk);
      {k_run, k_stop, k_dir} = 3'h0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [15:0] rg, input logic [15:0] val,
                     input logic bad, input logic ok);
      int n;
      logic hit;
      hit = 1'b0;
      master.send_frame(rg, val, bad);
      for (n = 0; n < 1000 && !(ok && done === 1'b1); n++) begin
         hit = hit | done;
         @(negedge sys_clk);
      end
      if (ok) chk("frame done", 16'h0001, {15'h0000, done});
      else chk("refused", 16'h0000, {15'h0000, hit});
      if (ok && done !== 1'b1) print_verdict();
      repeat (3) @(negedge sys_clk);
   endtask
   // w bits: run point write, direction point write
   task automatic fbw(input logic [1:0] w, input logic v);
      {fb_run_wr, fb_dir_wr} = w;
      fb_val = v;
      @(negedge sys_clk);
      {fb_run_wr, fb_dir_wr, fb_val} = 3'h0;
      repeat (3) @(negedge sys_clk);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk("fsrc", 16'h0000, {13'h0000, fsrc});
      chk("spd", freq.keypad, spd);
      chk("err", 16'h0000, {8'h00, fbs.error_code});
      chk("relays", 16'h0005, {13'h0000, fbs.relay_output_three,
          fbs.relay_output_two, fbs.relay_output_one});
      chk("disp", 16'h0002, {12'h000, disp});
   endtask
   task automatic t_keypad;
      key(3'h4);
      chk("run fwd", 16'h0002, {14'h0000, run, rev});
      key(3'h1);
      chk("dir", 16'h0003, {14'h0000, run, rev});
      key(3'h2);
      chk("stop", 16'h0000, {14'h0000, run, coast});
   endtask
   task automatic t_serial;
      wr(dsci_pkg::PAR_FREQ_SRC, 16'h0003, 1'b0, 1'b1);
      chk("fsrc3", 16'h0003, {13'h0000, fsrc});
      wr(16'h2502, 16'h9C40, 1'b0, 1'b1);
      chk("spd", 16'h9C40, spd);
      chk("spd word", 16'h9C40, spdw);
      wr(dsci_pkg::PAR_RUN_SRC, 16'h0002, 1'b0, 1'b1);
      chk("rsrc", 16'h0002, {14'h0000, rsrc});
      wr(16'h2501, 16'h0001, 1'b0, 1'b1);
      chk("fwd", 16'h0002, {14'h0000, run, rev});
      wr(16'h2501, 16'h0003, 1'b0, 1'b1);
      chk("both", 16'h0003, {14'h0000, run, rev});
      wr(16'h2501, 16'h0000, 1'b0, 1'b1);
      chk("halt", 16'h0000, {14'h0000, run, coast});
   endtask
   task automatic t_fb;
      fbw(2'h2, 1'b1);
      chk("fb run", 16'h0002, {14'h0000, run, rev});
      chk("cmd word", 16'h0001, cmdw);
      fbw(2'h1, 1'b1);
      chk("fb points", 16'h0003,
          {14'h0000, fbs.run_stop_point, fbs.direction_point});
      fbw(2'h2, 1'b0);
      chk("fb stop", 16'h0000, {14'h0000, run, rev});
   endtask
   task automatic t_params;
      wr(dsci_pkg::PAR_STOP_METHOD, 16'h0001, 1'b0, 1'b1);
      chk("coast", 16'h0001, {15'h0000, coast});
      wr(dsci_pkg::PAR_DISPLAY_UNIT, 16'h4E21, 1'b0, 1'b1);
      chk("disp user", 16'h000E, {12'h000, disp});
      wr(dsci_pkg::PAR_DISPLAY_UNIT, 16'h0004, 1'b0, 1'b1);
      chk("disp rpm", 16'h0008, {12'h000, disp});
      wr(dsci_pkg::PAR_REV_LOCK, 16'h0001, 1'b0, 1'b1);
      wr(16'h2501, 16'h0003, 1'b0, 1'b1);
      chk("rev lock", 16'h0000, {14'h0000, run, rev});
      chk("cmd word", 16'h0003, cmdw);
      wr(dsci_pkg::PAR_RUN_SRC, 16'h0001, 1'b0, 1'b1);
      req = 2'h2;
      repeat (3) @(negedge sys_clk);
      chk("terminal", 16'h0002, {14'h0000, run, rev});
      req = 2'h0;
   endtask
   task automatic t_errors;
      wr(16'h2502, 16'h1770, 1'b1, 1'b0);
      ident = 1'b1;
      @(negedge sys_clk);
      ident = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk("crc err", 16'h0002, {8'h00, fbs.error_code});
      chk("spd kept", 16'h9C40, spd);
      wr(16'h1234, 16'h0001, 1'b0, 1'b0);
      chk("range err", 16'h000A, {8'h00, fbs.error_code});
      master.send_byte(8'h01);
      repeat (1000) @(negedge sys_clk);
      chk("length err", 16'h0005, {8'h00, fbs.error_code});
   endtask
   initial begin
      {sys_rst, k_run, k_stop, k_dir, ident} = 5'h10;
      req = '0;
      {fb_run_wr, fb_dir_wr, fb_val} = 3'h0;
      relay = 3'h5;
      freq = {16'h01F4, 16'h0002, 16'h0003, 16'h0004, 16'h0005};
      repeat (2) @(negedge sys_clk);
      sys_rst = 1'b0;
      repeat (3) @(negedge sys_clk);
      t_reset();
      t_keypad();
      t_serial();
      t_fb();
      t_params();
      t_errors();
      print_verdict();
   end
endmodule
`default_nettype wire
